//--- rtl/pirq_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module pirq_ctrl
   import pirq_pkg::*;
#(
   parameter bit SMALL_PKG = 1'b0  // reduced pin count variant
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [PIRQ_AW-1:0] reg_addr,
   input wire logic [PIRQ_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [PIRQ_DW-1:0] reg_rdata,
   input wire logic [7:0] flags_1,   // latched event flags per group
   input wire logic [7:0] flags_2,
   input wire logic [7:0] flags_3,
   input wire logic [7:0] flags_4,
   input wire logic [7:0] flags_5,
   input wire logic [7:0] enable_1,  // first enable register, held outside
   input wire logic [7:0] prio_4,    // fourth and fifth priority, outside
   input wire logic [7:0] prio_5,
   output logic irq_high,            // high level (or single level) request
   output logic irq_low,             // low level request
   output logic irq_out              // enabled sticky status pending
);

   //------------------------------------------------
   // register storage
   //------------------------------------------------
   logic [7:0] periph_irq_enable_2_r;   // osc fail .. capcmp2
   logic [7:0] periph_irq_enable_3_r;   // serial2 .. rtc
   logic [7:0] periph_irq_enable_4_r;   // capcmp 10..4, capcmp3
   logic [7:0] periph_irq_enable_5_r;   // comparator3 .. timer1 gate
   logic [7:0] periph_irq_priority_1_r; // parallel port .. timer1 ovf
   logic [7:0] periph_irq_priority_2_r;
   logic [7:0] periph_irq_priority_3_r;
   logic global_priority_enable_r;      // two level mode
   logic global_peripheral_irq_enable_r; // single level gate
   logic [1:0] evt_status_r;            // sticky events
   logic [1:0] evt_enable_r;            // event to irq_out mask
   logic irq_high_r;
   logic irq_low_r;
   logic irq_high_d_r;                  // previous request, edge find
   logic irq_low_d_r;
   logic [7:0] pr1_mask;                // implemented priority one bits

   // decoded write strobes
   logic wr_en2, wr_en3, wr_en4, wr_en5;
   logic wr_pr1, wr_pr2, wr_pr3, wr_ctl, wr_icl, wr_ien;

   //------------------------------------------------
   // address decode
   //------------------------------------------------
   assign wr_en2 = reg_wr && (reg_addr == PIRQ_EN2_OFS);
   assign wr_en3 = reg_wr && (reg_addr == PIRQ_EN3_OFS);
   assign wr_en4 = reg_wr && (reg_addr == PIRQ_EN4_OFS);
   assign wr_en5 = reg_wr && (reg_addr == PIRQ_EN5_OFS);
   assign wr_pr1 = reg_wr && (reg_addr == PIRQ_PR1_OFS);
   assign wr_pr2 = reg_wr && (reg_addr == PIRQ_PR2_OFS);
   assign wr_pr3 = reg_wr && (reg_addr == PIRQ_PR3_OFS);
   assign wr_ctl = reg_wr && (reg_addr == PIRQ_CTL_OFS);
   assign wr_icl = reg_wr && (reg_addr == PIRQ_ICL_OFS);
   assign wr_ien = reg_wr && (reg_addr == PIRQ_IEN_OFS);

   // parallel port priority absent on the small package
   assign pr1_mask = SMALL_PKG ? ~(8'h01 << PIRQ_PR1_PMP_BIT) : 8'hFF;

   //------------------------------------------------
   // enable registers
   //------------------------------------------------
   // plain read/write, cleared at reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         periph_irq_enable_2_r <= PIRQ_EN_RST;
         periph_irq_enable_3_r <= PIRQ_EN_RST;
         periph_irq_enable_4_r <= PIRQ_EN_RST;
         periph_irq_enable_5_r <= PIRQ_EN_RST;
      end else begin
         if (wr_en2) begin
            periph_irq_enable_2_r <= reg_wdata;
         end
         if (wr_en3) begin
            periph_irq_enable_3_r <= reg_wdata;
         end
         if (wr_en4) begin
            periph_irq_enable_4_r <= reg_wdata;
         end
         if (wr_en5) begin
            // top two bits do not exist
            periph_irq_enable_5_r <= reg_wdata & PIRQ_EN5_MASK;
         end
      end
   end

   //------------------------------------------------
   // priority registers
   //------------------------------------------------
   // set at reset, so group 1 to 3 sources start high, bar parallel port on the small package
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         periph_irq_priority_1_r <= PIRQ_PR_RST & pr1_mask;
         periph_irq_priority_2_r <= PIRQ_PR_RST;
         periph_irq_priority_3_r <= PIRQ_PR_RST;
      end else begin
         if (wr_pr1) begin
            periph_irq_priority_1_r <= reg_wdata & pr1_mask;
         end
         if (wr_pr2) begin
            periph_irq_priority_2_r <= reg_wdata;
         end
         if (wr_pr3) begin
            periph_irq_priority_3_r <= reg_wdata;
         end
      end
   end

   //------------------------------------------------
   // global mode bits
   //------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         global_priority_enable_r <= PIRQ_CTL_RST[PIRQ_CTL_GLOBAL_PRIORITY_ENABLE_BIT];
         global_peripheral_irq_enable_r <= PIRQ_CTL_RST[PIRQ_CTL_GLOBAL_PERIPHERAL_IRQ_ENABLE_BIT];
      end else if (wr_ctl) begin
         global_priority_enable_r <= reg_wdata[PIRQ_CTL_GLOBAL_PRIORITY_ENABLE_BIT];
         global_peripheral_irq_enable_r <= reg_wdata[PIRQ_CTL_GLOBAL_PERIPHERAL_IRQ_ENABLE_BIT];
      end
   end

   //------------------------------------------------
   // per group request sort
   //------------------------------------------------
   logic [7:0] grp_flag [PIRQ_NG];  // event flags by group
   logic [7:0] grp_en [PIRQ_NG];    // enables by group
   logic [7:0] grp_pr [PIRQ_NG];    // priorities by group
   logic [PIRQ_NG-1:0] grp_act;     // any enabled flag
   logic [PIRQ_NG-1:0] grp_hi;      // any enabled high source
   logic [PIRQ_NG-1:0] grp_lo;      // any enabled low source

   assign grp_flag[0] = flags_1;
   assign grp_flag[1] = flags_2;
   assign grp_flag[2] = flags_3;
   assign grp_flag[3] = flags_4;
   assign grp_flag[4] = flags_5;
   assign grp_en[0] = enable_1;
   assign grp_en[1] = periph_irq_enable_2_r;
   assign grp_en[2] = periph_irq_enable_3_r;
   assign grp_en[3] = periph_irq_enable_4_r;
   assign grp_en[4] = periph_irq_enable_5_r;
   assign grp_pr[0] = periph_irq_priority_1_r;
   assign grp_pr[1] = periph_irq_priority_2_r;
   assign grp_pr[2] = periph_irq_priority_3_r;
   assign grp_pr[3] = prio_4;
   assign grp_pr[4] = prio_5;

   genvar g;
   generate
      for (g = 0; g < PIRQ_NG; g++) begin : g_grp
         // enable gates flag, priority picks level
         assign grp_act[g] = |(grp_flag[g] & grp_en[g]);
         assign grp_hi[g] = |(grp_flag[g] & grp_en[g] & grp_pr[g]);
         assign grp_lo[g] = |(grp_flag[g] & grp_en[g] & ~grp_pr[g]);
      end
   endgenerate

   //------------------------------------------------
   // request outputs
   //------------------------------------------------
   logic irq_high_nxt;
   logic irq_low_nxt;

   // single level: everything on the high line, behind the peripheral gate
   always_comb begin
      if (global_priority_enable_r) begin
         irq_high_nxt = |grp_hi;
         irq_low_nxt = |grp_lo;
      end else begin
         irq_high_nxt = global_peripheral_irq_enable_r && (|grp_act);
         irq_low_nxt = 1'b0;
      end
   end

   // one register stage: mask edits show next edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_high_r <= 1'b0;
         irq_low_r <= 1'b0;
         irq_high_d_r <= 1'b0;
         irq_low_d_r <= 1'b0;
      end else begin
         irq_high_r <= irq_high_nxt;
         irq_low_r <= irq_low_nxt;
         irq_high_d_r <= irq_high_r;
         irq_low_d_r <= irq_low_r;
      end
   end

   assign irq_high = irq_high_r;
   assign irq_low = irq_low_r;

   //------------------------------------------------
   // sticky event status
   //------------------------------------------------
   logic [1:0] evt_set;  // rising edges of the request lines

   assign evt_set = {irq_low_r & ~irq_low_d_r, irq_high_r & ~irq_high_d_r};

   // set beats a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         evt_status_r <= PIRQ_EV_RST;
      end else begin
         evt_status_r <= (evt_status_r & ~(wr_icl ? reg_wdata[1:0] : 2'h0)) | evt_set;
      end
   end

   // event enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         evt_enable_r <= PIRQ_EV_RST;
      end else if (wr_ien) begin
         evt_enable_r <= reg_wdata[1:0] & PIRQ_EV_MASK;
      end
   end

   assign irq_out = |(evt_status_r & evt_enable_r);

   //------------------------------------------------
   // read port
   //------------------------------------------------
   logic [7:0] rd_nxt;

   // unmapped and write-only offsets read zero
   always_comb begin
      case (reg_addr)
         PIRQ_EN2_OFS: rd_nxt = periph_irq_enable_2_r;
         PIRQ_EN3_OFS: rd_nxt = periph_irq_enable_3_r;
         PIRQ_EN4_OFS: rd_nxt = periph_irq_enable_4_r;
         PIRQ_EN5_OFS: rd_nxt = periph_irq_enable_5_r & PIRQ_EN5_MASK;
         PIRQ_PR1_OFS: rd_nxt = periph_irq_priority_1_r & pr1_mask;
         PIRQ_PR2_OFS: rd_nxt = periph_irq_priority_2_r;
         PIRQ_PR3_OFS: rd_nxt = periph_irq_priority_3_r;
         PIRQ_CTL_OFS: rd_nxt = {global_priority_enable_r,
                                 global_peripheral_irq_enable_r, 6'h00};
         PIRQ_IST_OFS: rd_nxt = {6'h00, evt_status_r};
         PIRQ_IEN_OFS: rd_nxt = {6'h00, evt_enable_r};
         default: rd_nxt = 8'h00;
      endcase
   end

   // data valid only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   //------------------------------------------------
   // assertions
   //------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_en5_top;
      periph_irq_enable_5_r[7:6] == 2'h0;
   endproperty
   a_en5_top: assert property (p_en5_top) else $error("enable5 top bits set");

   property p_en5_read;
      reg_rd && reg_addr == PIRQ_EN5_OFS |=> reg_rdata[7:6] == 2'h0;
   endproperty
   a_en5_read: assert property (p_en5_read) else $error("enable5 reads top bits");

   property p_rst_vals;
      !$past(rst_n) |-> periph_irq_enable_2_r == 8'h00 && periph_irq_priority_2_r == 8'hFF;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("wrong reset values");

   property p_en2_write;
      wr_en2 |=> periph_irq_enable_2_r == $past(reg_wdata);
   endproperty
   a_en2_write: assert property (p_en2_write) else $error("enable2 write lost");

   property p_single_low;
      !global_priority_enable_r |=> !irq_low;
   endproperty
   a_single_low: assert property (p_single_low) else $error("low line in single mode");

   property p_global_peripheral_irq_enable_gate;
      !global_priority_enable_r && !global_peripheral_irq_enable_r |=> !irq_high;
   endproperty
   a_global_peripheral_irq_enable_gate: assert property (p_global_peripheral_irq_enable_gate) else $error("request without gate");

   property p_high_req;
      global_priority_enable_r && (|grp_hi) |=> irq_high;
   endproperty
   a_high_req: assert property (p_high_req) else $error("high request missing");

   property p_blocked;
      !(|grp_act) |=> !irq_high && !irq_low;
   endproperty
   a_blocked: assert property (p_blocked) else $error("disabled source requested");

   property p_small_pkg;
      SMALL_PKG |-> !periph_irq_priority_1_r[PIRQ_PR1_PMP_BIT];
   endproperty
   a_small_pkg: assert property (p_small_pkg) else $error("parallel prio on small pkg");

   property p_evt_sticky;
      $rose(irq_high) |=> evt_status_r[PIRQ_EV_HI_BIT];
   endproperty
   a_evt_sticky: assert property (p_evt_sticky) else $error("high event not latched");

   property p_evt_sticky_lo;
      $rose(irq_low) |=> evt_status_r[PIRQ_EV_LO_BIT];
   endproperty
   a_evt_sticky_lo: assert property (p_evt_sticky_lo) else $error("low event not latched");

   // write paths land at the next edge
   property p_en4_write;
      wr_en4 |=> periph_irq_enable_4_r == $past(reg_wdata);
   endproperty
   a_en4_write: assert property (p_en4_write) else $error("enable4 write lost");

   property p_pr1_write;
      wr_pr1 |=> periph_irq_priority_1_r == ($past(reg_wdata) & pr1_mask);
   endproperty
   a_pr1_write: assert property (p_pr1_write) else $error("priority1 write lost");

   property p_pr2_write;
      wr_pr2 |=> periph_irq_priority_2_r == $past(reg_wdata);
   endproperty
   a_pr2_write: assert property (p_pr2_write) else $error("priority2 write lost");

   property p_pr3_write;
      wr_pr3 |=> periph_irq_priority_3_r == $past(reg_wdata);
   endproperty
   a_pr3_write: assert property (p_pr3_write) else $error("priority3 write lost");

   // enabled low source must reach the low line
   property p_low_req;
      global_priority_enable_r && (|grp_lo) |=> irq_low;
   endproperty
   a_low_req: assert property (p_low_req) else $error("low request missing");

   // single level: gated request on the high line
   property p_single_req;
      !global_priority_enable_r && global_peripheral_irq_enable_r && (|grp_act) |=> irq_high;
   endproperty
   a_single_req: assert property (p_single_req) else $error("no single request");

   c_high: cover property (global_priority_enable_r && irq_high);
   c_low: cover property (global_priority_enable_r && irq_low);
   c_single: cover property (!global_priority_enable_r && irq_high);
   c_irq: cover property (irq_out);

endmodule : pirq_ctrl
`default_nettype wire

//--- rtl/pirq_pkg.sv
//------------------------------------------------
// peripheral interrupt enable/priority constants
//------------------------------------------------
package pirq_pkg;
   localparam int unsigned PIRQ_AW = 12;  // register address width
   localparam int unsigned PIRQ_DW = 8;   // register data width
   localparam int unsigned PIRQ_NG = 5;   // source groups of eight
   // register offsets
   localparam logic [11:0] PIRQ_EN4_OFS = 12'hF8E;
   localparam logic [11:0] PIRQ_EN5_OFS = 12'hF91;
   localparam logic [11:0] PIRQ_PR1_OFS = 12'hF9F;
   localparam logic [11:0] PIRQ_EN2_OFS = 12'hFA0;
   localparam logic [11:0] PIRQ_PR2_OFS = 12'hFA2;
   localparam logic [11:0] PIRQ_EN3_OFS = 12'hFA3;
   localparam logic [11:0] PIRQ_PR3_OFS = 12'hFA5;
   localparam logic [11:0] PIRQ_CTL_OFS = 12'hFE0;  // global mode bits
   localparam logic [11:0] PIRQ_IST_OFS = 12'hFE1;  // sticky status, ro
   localparam logic [11:0] PIRQ_ICL_OFS = 12'hFE2;  // status clear, wo
   localparam logic [11:0] PIRQ_IEN_OFS = 12'hFE3;  // status enable
   // field positions
   localparam int unsigned PIRQ_CTL_GLOBAL_PRIORITY_ENABLE_BIT = 7;  // global_priority_enable
   localparam int unsigned PIRQ_CTL_GLOBAL_PERIPHERAL_IRQ_ENABLE_BIT = 6;  // global_peripheral_irq_enable
   localparam int unsigned PIRQ_EV_HI_BIT = 0;     // high request raised
   localparam int unsigned PIRQ_EV_LO_BIT = 1;     // low request raised
   localparam int unsigned PIRQ_PR1_PMP_BIT = 7;   // parallel_port_irq_prio
   // masks of implemented bits
   localparam logic [7:0] PIRQ_EN5_MASK = 8'h3F;
   localparam logic [7:0] PIRQ_CTL_MASK = 8'hC0;
   localparam logic [1:0] PIRQ_EV_MASK = 2'h3;
   // reset values
   localparam logic [7:0] PIRQ_EN_RST = 8'h00;
   localparam logic [7:0] PIRQ_PR_RST = 8'hFF;
   localparam logic [7:0] PIRQ_CTL_RST = 8'h00;
   localparam logic [1:0] PIRQ_EV_RST = 2'h0;
endpackage : pirq_pkg

//--- verif/pirq_src_model.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------
// peripheral event flag sources
//------------------------------------------
module pirq_src_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [39:0] set_vec,  // one-cycle event pulses
   input wire logic [39:0] clr_vec,  // software clear, set wins
   output logic [7:0] flags_1,
   output logic [7:0] flags_2,
   output logic [7:0] flags_3,
   output logic [7:0] flags_4,
   output logic [7:0] flags_5
);
   logic [39:0] flag_r;  // latched event flags
   // an event stays latched until software clears it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_r <= 40'h00_0000_0000;
      end else begin
         flag_r <= (flag_r & ~clr_vec) | set_vec;
      end
   end
   assign flags_1 = flag_r[7:0];
   assign flags_2 = flag_r[15:8];
   assign flags_3 = flag_r[23:16];
   assign flags_4 = flag_r[31:24];
   assign flags_5 = flag_r[39:32];
endmodule : pirq_src_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import pirq_pkg::*;
;
   //------------------------------------------
   // signals and tables
   //------------------------------------------
   typedef struct packed {
      logic [11:0] a;
      logic [7:0] r;
      logic [7:0] w;
      logic [7:0] e;
   } pirq_row_t;  // address, reset value, write, readback
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] enable_1 = 8'h00;
   logic [7:0] prio_4 = 8'h00;
   logic [7:0] prio_5 = 8'h00;
   logic [39:0] set_vec = 40'h00_0000_0000;
   logic [39:0] clr_vec = 40'h00_0000_0000;
   logic [7:0] reg_rdata, rdata_s, flags_1, flags_2, flags_3, flags_4, flags_5;
   logic [7:0] d, ds, m;  // read results, one-hot source mask
   logic irq_high, irq_low, irq_out, imp;
   int bad_count = 0;
   int n_tests = 0;
   pirq_row_t rows [11] = '{
      '{PIRQ_EN2_OFS, 8'h00, 8'hA5, 8'hA5}, '{PIRQ_EN3_OFS, 8'h00, 8'h5A, 8'h5A},
      '{PIRQ_EN4_OFS, 8'h00, 8'hC3, 8'hC3}, '{PIRQ_EN5_OFS, 8'h00, 8'hFF, 8'h3F},
      '{PIRQ_PR1_OFS, 8'hFF, 8'hDA, 8'hDA}, '{PIRQ_PR2_OFS, 8'hFF, 8'hA5, 8'hA5},
      '{PIRQ_PR3_OFS, 8'hFF, 8'h3C, 8'h3C}, '{PIRQ_CTL_OFS, 8'h00, 8'hC0, 8'hC0},
      '{PIRQ_IST_OFS, 8'h00, 8'hFF, 8'h00}, '{PIRQ_ICL_OFS, 8'h00, 8'hFF, 8'h00},
      '{12'h000, 8'h00, 8'hFF, 8'h00}};
   logic [7:0] ctl_v [3] = '{8'h00, 8'h40, 8'hC0};  // mode settings
   logic [2:0] irq_v [3] = '{3'b000, 3'b100, 3'b010};  // high, low, out
   always #10 mclk = ~mclk;
   //------------------------------------------
   // design, small variant and flag sources
   //------------------------------------------
   pirq_src_model i_src (.mclk(mclk), .rst_n(rst_n), .set_vec(set_vec), .clr_vec(clr_vec),
      .flags_1(flags_1), .flags_2(flags_2), .flags_3(flags_3), .flags_4(flags_4),
      .flags_5(flags_5));
   pirq_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flags_1(flags_1),
      .flags_2(flags_2), .flags_3(flags_3), .flags_4(flags_4), .flags_5(flags_5),
      .enable_1(enable_1), .prio_4(prio_4), .prio_5(prio_5), .irq_high(irq_high),
      .irq_low(irq_low), .irq_out(irq_out));
   pirq_ctrl #(.SMALL_PKG(1'b1)) i_small (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_s),
      .flags_1(flags_1), .flags_2(flags_2), .flags_3(flags_3), .flags_4(flags_4),
      .flags_5(flags_5), .enable_1(enable_1), .prio_4(prio_4), .prio_5(prio_5),
      .irq_high(), .irq_low(), .irq_out());
   //------------------------------------------
   // tasks
   //------------------------------------------
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   // request outputs packed as high, low, out
   task automatic chk_irq(input logic [2:0] exp);
      chk({5'h00, exp}, {5'h00, irq_high, irq_low, irq_out});
   endtask : chk_irq
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      ds = rdata_s;
   endtask : rd
   task automatic settle;
      @(posedge mclk);
      #1;
   endtask : settle
   // one event, every other flag cleared
   task automatic fire(input int idx);
      @(posedge mclk);
      set_vec <= 40'h00_0000_0001 << idx;
      clr_vec <= '1;
      @(posedge mclk);
      set_vec <= 40'h00_0000_0000;
      clr_vec <= 40'h00_0000_0000;
   endtask : fire
   task automatic set_en(input int g, input logic [7:0] v);
      case (g)
         1: begin
            @(posedge mclk);
            enable_1 <= v;
         end
         2: wr(PIRQ_EN2_OFS, v);
         3: wr(PIRQ_EN3_OFS, v);
         4: wr(PIRQ_EN4_OFS, v);
         default: wr(PIRQ_EN5_OFS, v);
      endcase
   endtask : set_en
   task automatic set_pr(input int g, input logic [7:0] v);
      case (g)
         1: wr(PIRQ_PR1_OFS, v);
         2: wr(PIRQ_PR2_OFS, v);
         3: wr(PIRQ_PR3_OFS, v);
         4: begin
            @(posedge mclk);
            prio_4 <= v;
         end
         default: begin
            @(posedge mclk);
            prio_5 <= v;
         end
      endcase
   endtask : set_pr
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   //------------------------------------------
   // stimulus
   //------------------------------------------
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      // reset values, access kinds, unmapped place
      foreach (rows[i]) begin
         rd(rows[i].a);
         chk(rows[i].r, d);
         if (rows[i].a == PIRQ_PR1_OFS) chk(rows[i].r & 8'h7F, ds);
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a);
         chk(rows[i].e, d);
         if (rows[i].a == PIRQ_PR1_OFS) chk(rows[i].e & 8'h7F, ds);
      end
      // every source alone: blocked, then high on odd bits, low on even, none for group 5 bits 6 and 7
      for (int g = 1; g <= 5; g++) begin
         for (int b = 0; b < 8; b++) begin
            m = 8'h01 << b;
            imp = !(g == 5 && b > 5);
            fire((g - 1) * 8 + b);
            set_pr(g, b[0] ? m : ~m);
            set_en(g, ~m);
            settle();
            chk_irq(3'b000);
            set_en(g, m);
            settle();
            chk_irq({imp & b[0], imp & ~b[0], 1'b0});
         end
      end
      // single level, gated, then two levels
      fire(8);
      set_pr(2, 8'h00);
      set_en(2, 8'h01);
      foreach (ctl_v[i]) begin
         wr(PIRQ_CTL_OFS, ctl_v[i]);
         settle();
         chk_irq(irq_v[i]);
      end
      chk(8'h01, flags_2);
      // sticky status, enable mask and clear
      rd(PIRQ_IST_OFS);
      chk(8'h03, d);
      wr(PIRQ_ICL_OFS, 8'h03);
      rd(PIRQ_IST_OFS);
      chk(8'h00, d);
      set_pr(2, 8'h01);
      settle();
      rd(PIRQ_IST_OFS);
      chk(8'h01, d);
      wr(PIRQ_IEN_OFS, 8'h02);
      settle();
      chk_irq(3'b100);
      wr(PIRQ_IEN_OFS, 8'h01);
      settle();
      chk_irq(3'b101);
      wr(PIRQ_ICL_OFS, 8'h01);
      settle();
      chk_irq(3'b100);
      // second reset in mid-run
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      chk_irq(3'b000);
      rd(PIRQ_EN2_OFS);
      chk(8'h00, d);
      rd(PIRQ_PR2_OFS);
      chk(8'hFF, d);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
